//--- rtl/can_diag_pkg.sv
// Constants, modes and carriers for the CAN diagnostic-mode and time-stamp block.
// Assumes a protocol core on the same clock that reports frame events and takes controls.
package can_diag_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] LEC_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] TS_CTRL_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] TX_REQ_OFS = 8'h14;

   localparam int MODE_LSB = 0;
   localparam int ALS_BIT = 4;
   localparam int VALF_BIT = 8;
   localparam int ST_TXC_BIT = 0;
   localparam int ST_PERR_BIT = 3;
   localparam int ST_ARB_BIT = 4;
   localparam int ST_WAKE_BIT = 5;
   localparam int TXC_IE_BIT = 0;
   localparam int TS_SEL_BIT = 0;
   localparam int TS_EN_BIT = 1;
   localparam int TS_LOCK_BIT = 2;
   localparam int TXRQ_BIT = 0;

   localparam logic RECESSIVE = 1'b1;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic TRIGGER_RESET = 1'b0;
   localparam logic [2:0] LEC_RESET = 3'h0;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      MODE_INIT = 3'b000,
      MODE_NORMAL = 3'b001,
      MODE_NORMAL_ABT = 3'b010,
      MODE_RX_ONLY = 3'b011,
      MODE_SINGLE_SHOT = 3'b100,
      MODE_SELF_TEST = 3'b101,
      MODE_SLEEP = 3'b110
   } op_mode_e;

   // Events from the protocol core, one-cycle pulses
   typedef struct packed {
      logic sof;
      logic eof_last;
      logic data_frame;
      logic rx_valid;
      logic tx_ok;
      logic arb_loss;
      logic error;
      logic [2:0] err_code;
      logic store_buf0_start;
   } core_evt_s;

   // Controls back to the protocol core, levels
   typedef struct packed {
      logic rx_bit;
      logic tx_start_permit;
      logic tec_update_enable;
      logic ack_assumed;
      logic retry_after_arb;
      logic retry_after_err;
   } core_ctl_s;

endpackage

//--- rtl/can_pin_sync.sv
// Two-flop synchroniser for the receive pin.
// Assumes an asynchronous input; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module can_pin_sync (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic pin_async,
   output logic pin_sync
);
   import can_diag_pkg::*;

   logic stage1;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= RECESSIVE;
         pin_sync <= RECESSIVE;
      end else begin
         stage1 <= pin_async;
         pin_sync <= stage1;
      end
   end
endmodule
`default_nettype wire

//--- rtl/can_diag_modes_timestamp.sv
// Diagnostic modes, sleep wake-up and time-stamp trigger for a CAN protocol core.
// Assumes the core runs on core_clk, pulses events in core_evt, and obeys core_ctl.
`timescale 1ns/1ps
`default_nettype none
module can_diag_modes_timestamp (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [can_diag_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [can_diag_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [can_diag_pkg::DATA_W-1:0] reg_rdata,
   input wire logic can_rx_pin,
   output logic can_tx_pin,
   input wire logic core_tx_bit,
   input wire can_diag_pkg::core_evt_s core_evt,
   output can_diag_pkg::core_ctl_s core_ctl,
   output logic irq_request,
   output logic wakeup_irq,
   output logic timestamp_capture_trigger
);
   import can_diag_pkg::*;

   op_mode_e mode;
   logic arb_loss_retry_select;
   logic valid_reception_flag;
   logic tx_complete_status;
   logic protocol_error_status;
   logic arb_loss_status;
   logic wakeup_status;
   logic tx_complete_irq_enable;
   logic [2:0] last_error_code_field;
   logic timestamp_event_select;
   logic timestamp_output_enable;
   logic timestamp_lock_enable;
   logic tx_request_flag;
   logic rx_sync;
   logic rx_prev;

   logic wr_ctrl;
   logic wr_status;
   logic wr_irq_en;
   logic wr_ts;
   logic wr_txreq;
   logic rx_fall;
   logic wake_event;
   logic pin_drive_ok;
   logic tx_capable;
   logic rx_capable;
   logic single_shot;
   logic tx_clear;
   logic ts_event;
   logic lock_hit;
   logic next_txc;
   logic next_wake;
   core_ctl_s next_ctl;
   logic [DATA_W-1:0] next_rdata;

   can_pin_sync u_rx_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin_async(can_rx_pin),
      .pin_sync(rx_sync)
   );

   assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
   assign wr_status = reg_wr && (reg_addr == STATUS_OFS);
   assign wr_irq_en = reg_wr && (reg_addr == IRQ_EN_OFS);
   assign wr_ts = reg_wr && (reg_addr == TS_CTRL_OFS);
   assign wr_txreq = reg_wr && (reg_addr == TX_REQ_OFS);

   // Mode decode
   always_comb begin
      pin_drive_ok = 1'b0;
      tx_capable = 1'b0;
      rx_capable = 1'b1;
      single_shot = 1'b0;
      case (mode)
         MODE_INIT: begin
            rx_capable = 1'b0;
         end
         MODE_NORMAL, MODE_NORMAL_ABT: begin
            pin_drive_ok = 1'b1;
            tx_capable = 1'b1;
         end
         MODE_SINGLE_SHOT: begin
            pin_drive_ok = 1'b1;
            tx_capable = 1'b1;
            single_shot = 1'b1;
         end
         MODE_RX_ONLY: begin
            pin_drive_ok = 1'b0;
            tx_capable = 1'b0;
         end
         MODE_SELF_TEST: begin
            pin_drive_ok = 1'b0;
            tx_capable = 1'b1;
         end
         MODE_SLEEP: begin
            rx_capable = 1'b0;
         end
         default: begin
            rx_capable = 1'b0;
         end
      endcase
   end

   // Wake-up on falling receive edge, also after sleep entered from self-test
   assign rx_fall = rx_prev && !rx_sync;
   assign wake_event = (mode == MODE_SLEEP) && rx_fall;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_prev <= RECESSIVE;
      end else begin
         rx_prev <= rx_sync;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode <= MODE_INIT;
         arb_loss_retry_select <= FLAG_RESET;
      end else begin
         if (wake_event) begin
            mode <= MODE_NORMAL;
         end else if (wr_ctrl) begin
            mode <= op_mode_e'(reg_wdata[MODE_LSB+:3]);
         end
         if (wr_ctrl) begin
            arb_loss_retry_select <= reg_wdata[ALS_BIT];
         end
      end
   end

   // Sticky valid reception, set wins over write-one-clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         valid_reception_flag <= FLAG_RESET;
      end else if (core_evt.rx_valid && rx_capable) begin
         valid_reception_flag <= 1'b1;
      end else if (wr_ctrl && reg_wdata[VALF_BIT]) begin
         valid_reception_flag <= 1'b0;
      end
   end

   // Status bits, write one to clear, hardware set wins
   always_comb begin
      next_txc = tx_complete_status;
      if (wr_status && reg_wdata[ST_TXC_BIT]) begin
         next_txc = 1'b0;
      end
      if (core_evt.tx_ok) begin
         next_txc = 1'b1;
      end
      next_wake = wakeup_status;
      if (wr_status && reg_wdata[ST_WAKE_BIT]) begin
         next_wake = 1'b0;
      end
      if (wake_event) begin
         next_wake = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_complete_status <= FLAG_RESET;
         wakeup_status <= FLAG_RESET;
         protocol_error_status <= FLAG_RESET;
         arb_loss_status <= FLAG_RESET;
         last_error_code_field <= LEC_RESET;
      end else begin
         tx_complete_status <= next_txc;
         wakeup_status <= next_wake;
         if (core_evt.error) begin
            protocol_error_status <= 1'b1;
            last_error_code_field <= core_evt.err_code;
         end else if (wr_status && reg_wdata[ST_PERR_BIT]) begin
            protocol_error_status <= 1'b0;
         end
         if (core_evt.arb_loss) begin
            arb_loss_status <= 1'b1;
         end else if (wr_status && reg_wdata[ST_ARB_BIT]) begin
            arb_loss_status <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_complete_irq_enable <= FLAG_RESET;
         irq_request <= FLAG_RESET;
         wakeup_irq <= FLAG_RESET;
      end else begin
         if (wr_irq_en) begin
            tx_complete_irq_enable <= reg_wdata[TXC_IE_BIT];
         end
         irq_request <= next_txc && tx_complete_irq_enable;
         wakeup_irq <= next_wake;
      end
   end

   // Transmit request: success always ends it; single-shot also on error, and on loss unless arb_loss_retry_select is set
   assign tx_clear = core_evt.tx_ok
      || (single_shot && core_evt.error)
      || (single_shot && core_evt.arb_loss && !arb_loss_retry_select);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_request_flag <= FLAG_RESET;
      end else if (wr_txreq) begin
         tx_request_flag <= reg_wdata[TXRQ_BIT];
      end else if (tx_clear) begin
         tx_request_flag <= 1'b0;
      end
   end

   // Controls to the protocol core
   always_comb begin
      next_ctl.rx_bit = (mode == MODE_SELF_TEST) ? core_tx_bit : rx_sync;
      next_ctl.tx_start_permit = tx_capable && tx_request_flag && !tx_clear;
      next_ctl.tec_update_enable = (mode != MODE_RX_ONLY);
      next_ctl.ack_assumed = (mode == MODE_RX_ONLY);
      next_ctl.retry_after_arb = !single_shot || arb_loss_retry_select;
      next_ctl.retry_after_err = !single_shot;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         core_ctl <= '{rx_bit: RECESSIVE, tec_update_enable: 1'b1, retry_after_arb: 1'b1,
                       retry_after_err: 1'b1, default: 1'b0};
         can_tx_pin <= RECESSIVE;
      end else begin
         core_ctl <= next_ctl;
         can_tx_pin <= pin_drive_ok ? core_tx_bit : RECESSIVE;
      end
   end

   // Time-stamp trigger
   assign ts_event = timestamp_output_enable && core_evt.data_frame
      && (timestamp_event_select ? core_evt.eof_last : core_evt.sof);
   assign lock_hit = timestamp_lock_enable && core_evt.store_buf0_start
      && (mode != MODE_NORMAL_ABT);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timestamp_capture_trigger <= TRIGGER_RESET;
      end else if (ts_event) begin
         timestamp_capture_trigger <= !timestamp_capture_trigger;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timestamp_event_select <= FLAG_RESET;
         timestamp_output_enable <= FLAG_RESET;
         timestamp_lock_enable <= FLAG_RESET;
      end else begin
         if (wr_ts) begin
            timestamp_event_select <= reg_wdata[TS_SEL_BIT];
            timestamp_lock_enable <= reg_wdata[TS_LOCK_BIT];
         end
         if (lock_hit) begin
            timestamp_output_enable <= 1'b0;
         end else if (wr_ts) begin
            timestamp_output_enable <= reg_wdata[TS_EN_BIT];
         end
      end
   end

   // Read port, data one cycle after the strobe
   always_comb begin
      next_rdata = RDATA_RESET;
      case (reg_addr)
         CTRL_OFS: begin
            next_rdata[MODE_LSB+:3] = mode;
            next_rdata[ALS_BIT] = arb_loss_retry_select;
            next_rdata[VALF_BIT] = valid_reception_flag;
         end
         STATUS_OFS: begin
            next_rdata[ST_TXC_BIT] = tx_complete_status;
            next_rdata[ST_PERR_BIT] = protocol_error_status;
            next_rdata[ST_ARB_BIT] = arb_loss_status;
            next_rdata[ST_WAKE_BIT] = wakeup_status;
         end
         IRQ_EN_OFS: begin
            next_rdata[TXC_IE_BIT] = tx_complete_irq_enable;
         end
         LEC_OFS: begin
            next_rdata[2:0] = last_error_code_field;
         end
         TS_CTRL_OFS: begin
            next_rdata[TS_SEL_BIT] = timestamp_event_select;
            next_rdata[TS_EN_BIT] = timestamp_output_enable;
            next_rdata[TS_LOCK_BIT] = timestamp_lock_enable;
         end
         TX_REQ_OFS: begin
            next_rdata[TXRQ_BIT] = tx_request_flag;
         end
         default: begin
            next_rdata = RDATA_RESET;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= RDATA_RESET;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= RDATA_RESET;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   sequence sleep_fall_s;
      (mode == MODE_SLEEP) ##0 rx_fall;
   endsequence

   sequence woken_s;
      (mode == MODE_NORMAL) && wakeup_status ##1 wakeup_irq;
   endsequence

   chk_rxonly_pin_recessive: assert property ((mode == MODE_RX_ONLY) [*2] |=> can_tx_pin)
      else $error("transmit pin driven in receive-only mode");

   chk_rxonly_no_start: assert property ((mode == MODE_RX_ONLY) |=> !core_ctl.tx_start_permit)
      else $error("transmit started in receive-only mode");

   chk_rxonly_keeps_request: assert property (
      (mode == MODE_RX_ONLY) && tx_request_flag && !wr_txreq && !core_evt.tx_ok |=> tx_request_flag)
      else $error("pending request dropped in receive-only mode");

   chk_rxonly_tec_frozen: assert property (
      (mode == MODE_RX_ONLY) |=> !core_ctl.tec_update_enable && core_ctl.ack_assumed)
      else $error("error counter update allowed in receive-only mode");

   chk_valid_set: assert property (core_evt.rx_valid && rx_capable |=> valid_reception_flag)
      else $error("valid reception not flagged");

   chk_valid_sticky: assert property (
      valid_reception_flag && !(wr_ctrl && reg_wdata[VALF_BIT]) |=> valid_reception_flag)
      else $error("valid reception flag lost without clear");

   chk_single_no_retry: assert property (
      single_shot && !arb_loss_retry_select |=> !core_ctl.retry_after_arb && !core_ctl.retry_after_err)
      else $error("retry allowed in single-shot mode");

   chk_single_arb_retry: assert property (
      single_shot && arb_loss_retry_select |=> core_ctl.retry_after_arb && !core_ctl.retry_after_err)
      else $error("single-shot retry select not obeyed");

   chk_other_mode_retry: assert property (
      !single_shot |=> core_ctl.retry_after_arb && core_ctl.retry_after_err)
      else $error("retry disabled outside single-shot mode");

   chk_single_error_clears: assert property (
      single_shot && core_evt.error && !wr_txreq |=> !tx_request_flag ##1 !core_ctl.tx_start_permit)
      else $error("request not cleared after single-shot error");

   chk_error_recorded: assert property (
      core_evt.error |=> protocol_error_status && (last_error_code_field == $past(core_evt.err_code)))
      else $error("error status or code not recorded");

   chk_txc_irq: assert property (
      core_evt.tx_ok && tx_complete_irq_enable |=> tx_complete_status && irq_request)
      else $error("transmit completion not signalled");

   chk_selftest_loop: assert property (
      (mode == MODE_SELF_TEST) |=> core_ctl.rx_bit == $past(core_tx_bit) && can_tx_pin)
      else $error("self-test loopback broken");

   chk_sleep_wake: assert property (sleep_fall_s |=> woken_s)
      else $error("no wake-up from sleep on falling edge");

   chk_ts_toggle: assert property (
      ts_event |=> timestamp_capture_trigger != $past(timestamp_capture_trigger))
      else $error("trigger did not toggle on event");

   chk_ts_frozen: assert property (!timestamp_output_enable |=> $stable(timestamp_capture_trigger))
      else $error("trigger moved while disabled");

   chk_ts_lock: assert property (
      lock_hit |=> !timestamp_output_enable ##1 $stable(timestamp_capture_trigger))
      else $error("lock did not freeze the trigger");

endmodule
`default_nettype wire

//--- verification/can_bus_node.sv
// Far-side model: other CAN nodes on a wired-AND bus, plus the capture timer.
// Assumes a recessive pull-up bus and a trigger on the same clock.
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic can_tx_pin,
   input wire logic dominant_req,
   input wire logic timestamp_capture_trigger,
   output logic can_rx_pin,
   output logic [15:0] capture_count
);
   logic trig_q;
   // Bus pulled recessive unless some node drives dominant
   assign can_rx_pin = can_tx_pin & ~dominant_req;
   // Capture on both edges of the trigger
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         trig_q <= 1'b0;
         capture_count <= 16'h0000;
      end else begin
         trig_q <= timestamp_capture_trigger;
         if (trig_q != timestamp_capture_trigger) begin
            capture_count <= capture_count + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/can_diag_modes_timestamp_tb.sv
// Self-checking bench for the diagnostic-mode and time-stamp block.
// Assumes the design package and the far-side bus node model.
`timescale 1ns/1ps
`default_nettype none
module can_diag_modes_timestamp_tb;
   import can_diag_pkg::*;
   logic core_clk, resetn, reg_wr, reg_rd, core_tx_bit, dominant_req, ts_exp;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rdata;
   logic can_rx_pin, can_tx_pin, irq_request, wakeup_irq, timestamp_capture_trigger;
   logic [15:0] capture_count;
   core_evt_s core_evt, ev;
   core_ctl_s core_ctl;
   int bad_count, cmp_count, cycles;

   can_diag_modes_timestamp can_diag_modes_timestamp_i (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin),
      .core_tx_bit(core_tx_bit), .core_evt(core_evt), .core_ctl(core_ctl),
      .irq_request(irq_request), .wakeup_irq(wakeup_irq),
      .timestamp_capture_trigger(timestamp_capture_trigger));
   can_bus_node can_bus_node_i (.core_clk(core_clk), .resetn(resetn), .can_tx_pin(can_tx_pin),
      .dominant_req(dominant_req), .timestamp_capture_trigger(timestamp_capture_trigger),
      .can_rx_pin(can_rx_pin), .capture_count(capture_count));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic final_report();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rdata = reg_rdata;
   endtask

   task automatic pulse(input core_evt_s e);
      @(posedge core_clk);
      core_evt <= e;
      @(posedge core_clk);
      core_evt <= '0;
      #1;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic t_reset();
      check(timestamp_capture_trigger, 1'b0);
      check(can_tx_pin, 1'b1);
      rd(CTRL_OFS);
      check(rdata[2:0], 3'h0);
      rd(8'h20);
      check(rdata, 32'h0000_0000);
   endtask

   task automatic t_rx_only();
      wr(CTRL_OFS, 32'h0000_0001);
      @(posedge core_clk) core_tx_bit <= 1'b0;
      cyc(3);
      check(can_tx_pin, 1'b0);
      wr(CTRL_OFS, 32'h0000_0003);
      wr(TX_REQ_OFS, 32'h0000_0001);
      cyc(3);
      check(can_tx_pin, 1'b1);
      check(can_rx_pin, 1'b1);
      check(core_ctl.tx_start_permit, 1'b0);
      check(core_ctl.tec_update_enable, 1'b0);
      check(core_ctl.ack_assumed, 1'b1);
      rd(TX_REQ_OFS);
      check(rdata[TXRQ_BIT], 1'b1);
      ev = '0;
      ev.rx_valid = 1'b1;
      pulse(ev);
      cyc(5);
      rd(CTRL_OFS);
      check(rdata[VALF_BIT], 1'b1);
      wr(CTRL_OFS, 32'h0000_0103);
      rd(CTRL_OFS);
      check(rdata[VALF_BIT], 1'b0);
      @(posedge core_clk) core_tx_bit <= 1'b1;
   endtask

   task automatic t_single();
      wr(CTRL_OFS, 32'h0000_0004);
      cyc(2);
      check(core_ctl.retry_after_arb, 1'b0);
      check(core_ctl.retry_after_err, 1'b0);
      ev = '0;
      ev.arb_loss = 1'b1;
      pulse(ev);
      rd(TX_REQ_OFS);
      check(rdata[TXRQ_BIT], 1'b0);
      rd(STATUS_OFS);
      check(rdata[ST_ARB_BIT], 1'b1);
      wr(STATUS_OFS, 32'h0000_0039);
      wr(CTRL_OFS, 32'h0000_0014);
      wr(TX_REQ_OFS, 32'h0000_0001);
      cyc(2);
      check(core_ctl.retry_after_arb, 1'b1);
      check(core_ctl.retry_after_err, 1'b0);
      pulse(ev);
      rd(TX_REQ_OFS);
      check(rdata[TXRQ_BIT], 1'b1);
      ev = '0;
      ev.error = 1'b1;
      ev.err_code = 3'h5;
      pulse(ev);
      rd(TX_REQ_OFS);
      check(rdata[TXRQ_BIT], 1'b0);
      rd(STATUS_OFS);
      check(rdata[ST_PERR_BIT], 1'b1);
      rd(LEC_OFS);
      check(rdata[2:0], 3'h5);
      wr(TX_REQ_OFS, 32'h0000_0001);
      wr(IRQ_EN_OFS, 32'h0000_0001);
      ev = '0;
      ev.tx_ok = 1'b1;
      pulse(ev);
      check(irq_request, 1'b1);
      rd(STATUS_OFS);
      check(rdata[ST_TXC_BIT], 1'b1);
      rd(TX_REQ_OFS);
      check(rdata[TXRQ_BIT], 1'b0);
      wr(STATUS_OFS, 32'h0000_0039);
      cyc(2);
      check(irq_request, 1'b0);
      wr(CTRL_OFS, 32'h0000_0001);
      cyc(2);
      check(core_ctl.retry_after_arb, 1'b1);
      check(core_ctl.retry_after_err, 1'b1);
   endtask

   task automatic t_self_sleep();
      wr(CTRL_OFS, 32'h0000_0005);
      @(posedge core_clk) core_tx_bit <= 1'b0;
      cyc(3);
      check(can_tx_pin, 1'b1);
      check(core_ctl.rx_bit, 1'b0);
      check(can_rx_pin, 1'b1);
      @(posedge core_clk) core_tx_bit <= 1'b1;
      wr(CTRL_OFS, 32'h0000_0006);
      @(posedge core_clk) dominant_req <= 1'b1;
      cyc(7);
      check(wakeup_irq, 1'b1);
      @(posedge core_clk) dominant_req <= 1'b0;
      rd(CTRL_OFS);
      check(rdata[2:0], 3'h1);
      rd(STATUS_OFS);
      check(rdata[ST_WAKE_BIT], 1'b1);
   endtask

   task automatic ts_ev(input logic s, input logic e, input logic d, input logic tog);
      ev = '0;
      ev.sof = s;
      ev.eof_last = e;
      ev.data_frame = d;
      pulse(ev);
      ts_exp = ts_exp ^ tog;
      check(timestamp_capture_trigger, ts_exp);
   endtask

   task automatic t_stamp();
      wr(TS_CTRL_OFS, 32'h0000_0002);
      ts_ev(1'b1, 1'b0, 1'b1, 1'b1);
      ts_ev(1'b1, 1'b0, 1'b0, 1'b0);
      ts_ev(1'b0, 1'b1, 1'b1, 1'b0);
      wr(TS_CTRL_OFS, 32'h0000_0003);
      ts_ev(1'b0, 1'b1, 1'b1, 1'b1);
      ts_ev(1'b0, 1'b1, 1'b1, 1'b1);
      wr(TS_CTRL_OFS, 32'h0000_0001);
      ts_ev(1'b0, 1'b1, 1'b1, 1'b0);
      wr(TS_CTRL_OFS, 32'h0000_0006);
      ts_ev(1'b1, 1'b0, 1'b1, 1'b1);
      ev = '0;
      ev.store_buf0_start = 1'b1;
      pulse(ev);
      rd(TS_CTRL_OFS);
      check(rdata[TS_EN_BIT], 1'b0);
      ts_ev(1'b1, 1'b0, 1'b1, 1'b0);
      wr(CTRL_OFS, 32'h0000_0002);
      wr(TS_CTRL_OFS, 32'h0000_0006);
      ev = '0;
      ev.store_buf0_start = 1'b1;
      pulse(ev);
      rd(TS_CTRL_OFS);
      check(rdata[TS_EN_BIT], 1'b1);
      ts_ev(1'b1, 1'b0, 1'b1, 1'b1);
      cyc(2);
      check(capture_count, 16'h0005);
   endtask

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      core_tx_bit = 1'b1;
      dominant_req = 1'b0;
      core_evt = '0;
      ev = '0;
      ts_exp = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      t_reset();
      t_rx_only();
      t_single();
      t_self_sleep();
      t_stamp();
      final_report();
   end
endmodule
`default_nettype wire
